// file: verilog/qbsi_core.sv
// device-side logic of the burst-of-two separate-port memory interface
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Each read and each write moves exactly two beats at one address.
// - Read data leaves on its own bus while write data arrives on another, both at once.
// - The first read beat leaves on the third following complementary-clock rise.
// - The second read beat leaves on the third true-clock rise, right after the first.
// - Commands are taken on a true-clock rise and the rest of the operation runs by itself.
// - The address is taken on both clock rises: read address on true, write on complementary.
// - Write data waits in an internal write buffer since it arrives before the write address.
// - Each byte lane has its own active-low enable per beat and only enabled bytes change.
// - Two complementary echo clocks move together with the read data.
// - The array is 2M words of 36 bits or 4M words of 18 bits, with matching byte enables.
// - The output-valid flag is high while read data is valid, aligned with the echo clocks.
// - With the DLL-off input low the read latency drops to one cycle.
module qbsi_core
	import qbsi_pkg::*;
(
	// system
	input  wire logic          clk,
	input  wire logic          resetn,
	// link clock pair
	input  wire logic          k_in,
	input  wire logic          k_in_comp,
	input  wire logic          dll_off_n,
	// command and address
	input  wire logic          read_sel_n,
	input  wire logic          write_sel_n,
	input  wire logic [AW-1:0] addr_in,
	// write port
	input  wire logic [DW-1:0] write_data_bus,
	input  wire logic [NB-1:0] byte_write_en_n,
	// read port
	output logic [DW-1:0]      read_data_bus,
	output logic               echo_timing_true,
	output logic               echo_timing_comp,
	output logic               output_valid_flag,
	output logic               rd_buf_ready
);
	// array sized by organisation, two beats per word
	qbsi_burst_t mem [0:(1<<AW)-1];

	qbsi_pins_t  sync1_r, sync2_r;
	logic        k_prev_r, kb_prev_r;
	logic        k_rise, kb_rise, tick;

	qbsi_rd_t    pipe_r   [0:PIPE_LEN-1];
	qbsi_rd_t    pipe_nxt [0:PIPE_LEN-1];
	qbsi_wbuf_t  wbuf_r, wbuf_nxt;
	qbsi_burst_t fifo_r [0:BUF_DEPTH-1];
	qbsi_burst_t fifo_nxt [0:BUF_DEPTH-1];
	logic        wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic [1:0]  cnt_r, cnt_nxt;
	qbsi_out_t   ost_r, ost_nxt;
	logic [DW-1:0] hold_r, hold_nxt, q_r, q_nxt;
	logic        vld_r, vld_nxt, ready_r, ready_nxt;
	logic        cq_r, cqn_r;
	logic        commit, fetch, launch;
	qbsi_rd_t    fetch_e, launch_e;
	qbsi_burst_t fetch_d, commit_d;

	// byte-masked merge of a burst over an old burst, used for commit and forwarding
	function automatic qbsi_burst_t merge(input qbsi_burst_t old_d, input qbsi_burst_t new_d,
			input logic [2*NB-1:0] be_n);
		qbsi_burst_t r;
		r = old_d;
		for (int i = 0; i < NB; i++) begin
			if (!be_n[i])
				r.b0[i*9 +: 9] = new_d.b0[i*9 +: 9];
			if (!be_n[NB+i])
				r.b1[i*9 +: 9] = new_d.b1[i*9 +: 9];
		end
		return r;
	endfunction

	// every pin passes two flops; edges are found on the second stage only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_r   <= PINS_RST;
			sync2_r   <= PINS_RST;
			k_prev_r  <= 1'b0;
			kb_prev_r <= 1'b0;
		end else begin
			sync1_r   <= '{rd_n: read_sel_n, wr_n: write_sel_n, addr: addr_in,
				data: write_data_bus, bwe_n: byte_write_en_n, k: k_in, kb: k_in_comp,
				doff_n: dll_off_n};
			sync2_r   <= sync1_r;
			k_prev_r  <= sync2_r.k;
			kb_prev_r <= sync2_r.kb;
		end
	end

	assign k_rise  = sync2_r.k & ~k_prev_r;
	assign kb_rise = sync2_r.kb & ~kb_prev_r;
	assign tick    = k_rise | kb_rise;

	// latency mode picks where a read is fetched and launched
	always_comb begin
		if (sync2_r.doff_n) begin
			fetch_e  = pipe_r[LAUNCH_DLL-2];
			launch_e = pipe_r[LAUNCH_DLL-1];
		end else begin
			fetch_e  = pipe_r[LAUNCH_NODLL-2];
			launch_e = pipe_r[LAUNCH_NODLL-1];
		end
		fetch  = tick & fetch_e.v;
		launch = tick & launch_e.v;
		commit = k_rise & wbuf_r.v;
		// the buffered write is newer than the array, so it wins on a match
		fetch_d = mem[fetch_e.a];
		if (wbuf_r.v && wbuf_r.a == fetch_e.a)
			fetch_d = merge(fetch_d, wbuf_r.d, wbuf_r.be_n);
		commit_d = merge(mem[wbuf_r.a], wbuf_r.d, wbuf_r.be_n);
	end

	// read pipeline in half-cycle ticks and the write buffer
	always_comb begin
		for (int i = 0; i < PIPE_LEN; i++)
			pipe_nxt[i] = pipe_r[i];
		wbuf_nxt = wbuf_r;
		if (tick) begin
			pipe_nxt[0].v = k_rise & ~sync2_r.rd_n;
			pipe_nxt[0].a = sync2_r.addr;
			for (int i = 1; i < PIPE_LEN; i++)
				pipe_nxt[i] = pipe_r[i-1];
		end
		if (commit)
			wbuf_nxt.v = 1'b0;
		if (k_rise && !sync2_r.wr_n) begin
			// beat one comes with the command, address follows half a cycle later
			wbuf_nxt.v              = 1'b0;
			wbuf_nxt.half           = 1'b1;
			wbuf_nxt.d.b0           = sync2_r.data;
			wbuf_nxt.be_n[NB-1:0]   = sync2_r.bwe_n;
		end else if (kb_rise && wbuf_r.half) begin
			wbuf_nxt.v              = 1'b1;
			wbuf_nxt.half           = 1'b0;
			wbuf_nxt.a              = sync2_r.addr;
			wbuf_nxt.d.b1           = sync2_r.data;
			wbuf_nxt.be_n[2*NB-1:NB] = sync2_r.bwe_n;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < PIPE_LEN; i++)
				pipe_r[i] <= RD_RST;
			wbuf_r <= WBUF_RST;
		end else begin
			for (int i = 0; i < PIPE_LEN; i++)
				pipe_r[i] <= pipe_nxt[i];
			wbuf_r <= wbuf_nxt;
		end
	end

	// the array is written only from the completed buffer, never straight from the pins
	always_ff @(posedge clk) begin
		if (commit)
			mem[wbuf_r.a] <= commit_d;
	end

	// two-entry buffer between fetch and launch; launch drains it
	always_comb begin
		for (int i = 0; i < BUF_DEPTH; i++)
			fifo_nxt[i] = fifo_r[i];
		wptr_nxt = wptr_r;
		rptr_nxt = rptr_r;
		cnt_nxt  = cnt_r;
		if (fetch && cnt_r != 2'(BUF_DEPTH)) begin
			fifo_nxt[wptr_r] = fetch_d;
			wptr_nxt = ~wptr_r;
			cnt_nxt  = cnt_nxt + 2'h1;
		end
		if (launch && cnt_r != 2'h0) begin
			rptr_nxt = ~rptr_r;
			cnt_nxt  = cnt_nxt - 2'h1;
		end
		ready_nxt = (cnt_nxt != 2'(BUF_DEPTH));
	end

	// output stage: beat one, then beat two on the next tick
	always_comb begin
		ost_nxt  = ost_r;
		hold_nxt = hold_r;
		q_nxt    = q_r;
		vld_nxt  = vld_r;
		if (tick) begin
			case (ost_r)
				OUT_BEAT0: begin
					q_nxt   = hold_r;
					vld_nxt = 1'b1;
					ost_nxt = OUT_BEAT1;
				end
				default: begin
					vld_nxt = 1'b0;
					ost_nxt = OUT_IDLE;
				end
			endcase
			if (launch && cnt_r != 2'h0) begin
				q_nxt    = fifo_r[rptr_r].b0;
				hold_nxt = fifo_r[rptr_r].b1;
				vld_nxt  = 1'b1;
				ost_nxt  = OUT_BEAT0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < BUF_DEPTH; i++)
				fifo_r[i] <= '0;
			wptr_r  <= 1'b0;
			rptr_r  <= 1'b0;
			cnt_r   <= 2'h0;
			ready_r <= 1'b1;
			ost_r   <= OUT_IDLE;
			hold_r  <= '0;
			q_r     <= '0;
			vld_r   <= 1'b0;
			cq_r    <= 1'b0;
			cqn_r   <= 1'b0;
		end else begin
			for (int i = 0; i < BUF_DEPTH; i++)
				fifo_r[i] <= fifo_nxt[i];
			wptr_r  <= wptr_nxt;
			rptr_r  <= rptr_nxt;
			cnt_r   <= cnt_nxt;
			ready_r <= ready_nxt;
			ost_r   <= ost_nxt;
			hold_r  <= hold_nxt;
			q_r     <= q_nxt;
			vld_r   <= vld_nxt;
			// echoes take the same sampled clocks as the data update, so edges stay together
			cq_r    <= sync2_r.k;
			cqn_r   <= sync2_r.kb;
		end
	end

	assign read_data_bus     = q_r;
	assign echo_timing_true  = cq_r;
	assign echo_timing_comp  = cqn_r;
	assign output_valid_flag = vld_r;
	assign rd_buf_ready      = ready_r;
endmodule

`default_nettype wire

// file: verilog/qbsi_pkg.sv
// constants and carrier types for the burst-of-two separate-port memory interface
package qbsi_pkg;
	// organisation: 1 selects 2M x 36, 0 selects 4M x 18
	localparam bit ORG_X36      = 1'b1;
	localparam int DW           = ORG_X36 ? 36 : 18;
	localparam int NB           = DW / 9;
	localparam int AW           = ORG_X36 ? 21 : 22;
	localparam int BURST_LEN    = 2;
	// launch and fetch points, counted in half-cycle ticks of the link clock pair
	localparam int LAUNCH_DLL   = 5;
	localparam int LAUNCH_NODLL = 2;
	localparam int PIPE_LEN     = LAUNCH_DLL;
	localparam int BUF_DEPTH    = 2;
	localparam int DLL_OFF_MAX_MHZ = 167;
	localparam int CLK_MHZ      = 100;

	typedef struct packed {
		logic          rd_n;
		logic          wr_n;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic [NB-1:0] bwe_n;
		logic          k;
		logic          kb;
		logic          doff_n;
	} qbsi_pins_t;

	typedef struct packed {
		logic [DW-1:0] b1;
		logic [DW-1:0] b0;
	} qbsi_burst_t;

	typedef struct packed {
		logic          v;
		logic [AW-1:0] a;
	} qbsi_rd_t;

	typedef struct packed {
		logic            v;
		logic            half;
		logic [AW-1:0]   a;
		qbsi_burst_t     d;
		logic [2*NB-1:0] be_n;
	} qbsi_wbuf_t;

	typedef enum logic [2:0] {
		OUT_IDLE  = 3'b001,
		OUT_BEAT0 = 3'b010,
		OUT_BEAT1 = 3'b100
	} qbsi_out_t;

	localparam qbsi_pins_t PINS_RST = '{rd_n: 1'b1, wr_n: 1'b1, bwe_n: '1, doff_n: 1'b1,
		default: '0};
	localparam qbsi_rd_t   RD_RST   = '{default: '0};
	localparam qbsi_wbuf_t WBUF_RST = '{be_n: '1, default: '0};
endpackage

// file: bench/qbsi_ctl.sv
// far-side controller model: link clocks and burst commands
`timescale 1ns/10ps
`default_nettype none
module qbsi_ctl
	import qbsi_pkg::*;
(
	// link pins
	output logic          k,
	output logic          kb,
	output logic          rd_n,
	output logic          wr_n,
	output logic [AW-1:0] a,
	output logic [DW-1:0] d,
	output logic [NB-1:0] be_n
);
	// one request waits here for the link cycle that carries it; only the loop touches the pins
	logic            req_v = 1'b0;
	logic            act;
	logic            req_r, req_w;
	logic [AW-1:0]   req_ra, req_wa;
	qbsi_burst_t     req_d;
	logic [2*NB-1:0] req_be;
	event            taken;
	// pins move a quarter period from each link rise; idle address and data buses toggle so no stale value looks valid
	// the 1 ns start offset keeps every link edge off the system clock's edges
	initial begin
		k = 1'b0;
		kb = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		a = '0;
		d = '0;
		be_n = '1;
		act = 1'b0;
		#1;
		forever begin
			#31.25;
			act = req_v;
			req_v = 1'b0;
			if (act) begin
				rd_n = req_r;
				wr_n = req_w;
				a = req_ra;
				d = req_d.b0;
				be_n = req_be[NB-1:0];
			end else begin
				rd_n = 1'b1;
				wr_n = 1'b1;
				a = ~a;
				d = ~d;
			end
			#31.25 k = 1'b1;
			kb = 1'b0;
			#31.25;
			if (act) begin
				a = req_wa;
				d = req_d.b1;
				be_n = req_be[2*NB-1:NB];
				->taken;
			end else begin
				a = ~a;
				d = ~d;
			end
			#31.25 k = 1'b0;
			kb = 1'b1;
		end
	end
	task automatic op(input logic r, w, input logic [AW-1:0] ra, wa, input qbsi_burst_t dd,
		input logic [2*NB-1:0] be);
		req_r = r;
		req_w = w;
		req_ra = ra;
		req_wa = wa;
		req_d = dd;
		req_be = be;
		req_v = 1'b1;
		@(taken);
	endtask
endmodule
`default_nettype wire

// file: bench/qbsi_core_chk.sv
// port checker for the burst memory interface
`timescale 1ns/10ps
`default_nettype none
module qbsi_core_chk
	import qbsi_pkg::*;
(
	// system and link
	input wire logic          clk,
	input wire logic          resetn,
	input wire logic          k_in,
	input wire logic          k_in_comp,
	input wire logic          dll_off_n,
	input wire logic          read_sel_n,
	input wire logic          write_sel_n,
	input wire logic [AW-1:0] addr_in,
	input wire logic [DW-1:0] write_data_bus,
	input wire logic [NB-1:0] byte_write_en_n,
	// read port
	input wire logic [DW-1:0] read_data_bus,
	input wire logic          echo_timing_true,
	input wire logic          echo_timing_comp,
	input wire logic          output_valid_flag,
	input wire logic          rd_buf_ready
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence rd_take(m);
		$rose(k_in) && !read_sel_n && dll_off_n == m;
	endsequence
	sequence echo_edge;
		$changed(echo_timing_true) || $changed(echo_timing_comp);
	endsequence
	rd_lat_a: assert property (rd_take(1'b1) |-> ##[28:35] output_valid_flag)
		else $error("read beat late");
	short_lat_a: assert property (rd_take(1'b0) |-> ##[10:16] output_valid_flag)
		else $error("short read late");
	beat0_comp_a: assert property ($rose(output_valid_flag) && dll_off_n |-> $rose(echo_timing_comp))
		else $error("first beat off edge");
	beat1_true_a: assert property ($rose(output_valid_flag) && dll_off_n |->
		##[4:9] $rose(echo_timing_true) && output_valid_flag)
		else $error("second beat missing");
	valid_align_a: assert property ($changed(output_valid_flag) |-> echo_edge)
		else $error("valid off echo");
	data_align_a: assert property (output_valid_flag && $past(output_valid_flag) &&
		$changed(read_data_bus) |-> echo_edge)
		else $error("data off echo");
	echo_follow_a: assert property ($rose(echo_timing_true) |-> $past(k_in, 3))
		else $error("echo not from link clock");
	two_beats_a: assert property ($rose(output_valid_flag) |-> output_valid_flag[*8])
		else $error("burst too short");
	beat_hold_a: assert property ($rose(output_valid_flag) |=> $stable(read_data_bus)[*4])
		else $error("beat not held");
endmodule
bind qbsi_core qbsi_core_chk i_chk (.clk, .resetn, .k_in, .k_in_comp, .dll_off_n, .read_sel_n,
	.write_sel_n, .addr_in, .write_data_bus, .byte_write_en_n, .read_data_bus,
	.echo_timing_true, .echo_timing_comp, .output_valid_flag, .rd_buf_ready);
`default_nettype wire

// file: bench/qbsi_core_tb.sv
// testbench for the burst memory interface
`timescale 1ns/10ps
`default_nettype none
module qbsi_core_tb
	import qbsi_pkg::*;
;
	localparam logic [AW-1:0]   AA = 21'h0a5;
	localparam logic [AW-1:0]   AB = 21'h1f0;
	localparam qbsi_burst_t     D1 = {DW'(36'h123456789), DW'(36'h9abcdef01)};
	localparam qbsi_burst_t     D2 = {DW'(36'hfedcba987), DW'(36'h0f0f0f0f0)};
	localparam qbsi_burst_t     D3 = {DW'(36'h5a5a5a5a5), DW'(36'h3c3c3c3c3)};
	localparam logic [2*NB-1:0] BE = 8'h5a;
	logic          clk = 1'b0;
	logic          resetn = 1'b0;
	logic          dll_off_n = 1'b1;
	logic          k_in, k_in_comp, read_sel_n, write_sel_n;
	logic [AW-1:0] addr_in;
	logic [DW-1:0] write_data_bus, read_data_bus;
	logic [NB-1:0] byte_write_en_n;
	logic          echo_timing_true, echo_timing_comp, output_valid_flag, rd_buf_ready;
	int            error_cnt = 0;
	int            n_checks = 0;
	always #5 clk = ~clk;
	qbsi_core i_dut (.clk, .resetn, .k_in, .k_in_comp, .dll_off_n, .read_sel_n, .write_sel_n,
		.addr_in, .write_data_bus, .byte_write_en_n, .read_data_bus, .echo_timing_true,
		.echo_timing_comp, .output_valid_flag, .rd_buf_ready);
	qbsi_ctl i_ctl (.k(k_in), .kb(k_in_comp), .rd_n(read_sel_n), .wr_n(write_sel_n),
		.a(addr_in), .d(write_data_bus), .be_n(byte_write_en_n));
	function automatic qbsi_burst_t merge(qbsi_burst_t o, n, logic [2*NB-1:0] be);
		for (int i = 0; i < 2*DW; i++)
			if (!be[i/9]) o[i] = n[i];
		return o;
	endfunction
	task automatic final_report();
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [DW-1:0] e, s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	// beats taken one echo edge apart; valid must drop at the edge after beat two
	task automatic rd_wait(input qbsi_burst_t e);
		int n;
		n = 0;
		while (output_valid_flag !== 1'b1 && n < 60) begin
			@(posedge clk) #1;
			n++;
		end
		chk("valid0", DW'(1'b1), DW'(output_valid_flag));
		chk("beat0", e.b0, read_data_bus);
		@(echo_timing_true or echo_timing_comp) #1;
		chk("valid1", DW'(1'b1), DW'(output_valid_flag));
		chk("beat1", e.b1, read_data_bus);
		@(echo_timing_true or echo_timing_comp) #1;
		chk("valid_end", DW'(1'b0), DW'(output_valid_flag));
	endtask
	// read, optionally with a write in the same cycle
	task automatic rd_chk(input logic [AW-1:0] ra, input qbsi_burst_t e, input logic w,
		input logic [AW-1:0] wa, input qbsi_burst_t dd, input logic [2*NB-1:0] be);
		i_ctl.op(1'b0, w, ra, wa, dd, be);
		rd_wait(e);
	endtask
	task automatic t_basic();
		chk("ready", DW'(1'b1), DW'(rd_buf_ready));
		i_ctl.op(1'b1, 1'b0, '0, AA, D1, '0);
		rd_chk(AA, D1, 1'b1, '0, '0, '1);
	endtask
	task automatic t_concur();
		rd_chk(AA, D1, 1'b0, AB, D3, '0);
	endtask
	task automatic t_bytes();
		i_ctl.op(1'b1, 1'b0, '0, AA, D2, BE);
		rd_chk(AA, merge(D1, D2, BE), 1'b1, '0, '0, '1);
		rd_chk(AB, D3, 1'b1, '0, '0, '1);
	endtask
	// latency mode only changes with nothing in flight
	task automatic t_dll();
		@(posedge clk) #1 dll_off_n = 1'b0;
		repeat (40) @(posedge clk);
		rd_chk(AB, D3, 1'b1, '0, '0, '1);
		repeat (40) @(posedge clk);
		#1 dll_off_n = 1'b1;
	endtask
	// a write issued one cycle after a read is still buffered when that read fetches
	task automatic t_fwd();
		repeat (4) @(posedge clk) #1;
		i_ctl.op(1'b0, 1'b1, AB, '0, '0, '1);
		i_ctl.op(1'b1, 1'b0, '0, AB, D2, BE);
		rd_wait(merge(D3, D2, BE));
	endtask
	initial begin
		#50000;
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		t_basic();
		t_concur();
		t_bytes();
		t_dll();
		t_fwd();
		final_report();
	end
endmodule
`default_nettype wire
